// [bench/dbrd_checker.sv]
/*
  Timing checker for dbrd_top, bound to its ports.
  Assumes one pclk domain and presetn active low.
*/
`timescale 1ns/1ps
`include "dbrd_regs.vh"
module dbrd_checker #(
  parameter CODE_W = 4
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // select pins
  input wire rx_load_pulse,
  input wire [CODE_W-1:0] rx_divisor_code,
  input wire tx_load_pulse,
  input wire [CODE_W-1:0] tx_divisor_code,
  // outputs
  input wire rx_rate_out,
  input wire tx_rate_out,
  input wire quarter_ref_out
);
  // decoded map; anything else must be refused
  wire mapped = paddr == `DBRD_CTRL_ADDR || paddr == `DBRD_LOAD_ADDR ||
    paddr == `DBRD_STAT_ADDR || (paddr >= `DBRD_TABLE_BASE && paddr <= `DBRD_TABLE_END &&
    paddr[1:0] == 2'h0);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait; psel && !penable |-> ##2 pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_map; pready |-> pslverr == !mapped; endproperty
  property p_errq; pslverr |-> pready; endproperty
  property p_zero; !pready |-> prdata == 32'h0; endproperty
  property p_quarter; $changed(quarter_ref_out) |=> $stable(quarter_ref_out); endproperty
  // level loading: a code change under a held load restarts the divider
  property p_rx_new;
    rx_load_pulse && $past(rx_load_pulse) && $changed(rx_divisor_code) |-> ##[3:6] rx_rate_out;
  endproperty
  property p_tx_new;
    tx_load_pulse && $past(tx_load_pulse) && $changed(tx_divisor_code) |-> ##[3:6] tx_rate_out;
  endproperty
  a_wait: assert property (p_wait) else $error("no ready after setup");
  a_pulse: assert property (p_pulse) else $error("ready held");
  a_map: assert property (p_map) else $error("wrong error response");
  a_errq: assert property (p_errq) else $error("error without ready");
  a_zero: assert property (p_zero) else $error("read data outside ready");
  a_quarter: assert property (p_quarter) else $error("quarter too fast");
  a_rx_new: assert property (p_rx_new) else $error("rx not restarted");
  a_tx_new: assert property (p_tx_new) else $error("tx not restarted");
  c_lvl: cover property (rx_load_pulse && $past(rx_load_pulse) && $changed(rx_divisor_code));
  c_err: cover property (pready && pslverr);
  c_wr: cover property (pready && pwrite);
endmodule
bind dbrd_top dbrd_checker #(.CODE_W(CODE_W)) u_chk (.*);

// [bench/dbrd_rate_meter.sv]
/*
  Uart-side clock input model: cycles between rising edges of one rate pin.
  Assumes the pin is a registered pclk-domain level.
*/
`timescale 1ns/1ps
module dbrd_rate_meter (
  // clock
  input wire pclk,
  // pin and result
  input wire rate,
  output reg [15:0] period = 16'h0000,
  output reg done = 1'b0
);
  reg last = 1'b0;
  reg [15:0] cnt = 16'h0000;
  // no reset on a uart clock pin, so the first period is junk
  always @(posedge pclk) begin
    last <= rate;
    cnt <= (rate && !last) ? 16'h0001 : cnt + 16'h0001;
    period <= (rate && !last) ? cnt : period;
    done <= rate && !last;
  end
endmodule

// [bench/dbrd_top_bench.sv]
/*
  Self-checking bench for dbrd_top: apb master, select pins, four rate meters.
  Assumes a 100 MHz pclk and the divisor table built below.
*/
`timescale 1ns/1ps
`include "dbrd_regs.vh"
module dbrd_top_bench;
  function automatic [239:0] mk_tab();
    for (int i = 0; i < 16; i++) mk_tab[i*15+:15] = 15'(i + 3);
  endfunction
  localparam [239:0] TAB = mk_tab();
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, reference_input = 1'b0;
  logic rx_rate_out, tx_rate_out, rate_out, quarter_ref_out;
  logic rx_load_pulse = 1'b0, tx_load_pulse = 1'b0, load_pulse = 1'b0;
  logic [3:0] rx_divisor_code = 4'h0, tx_divisor_code = 4'h0, divisor_code = 4'h0;
  logic [63:0] m_per;
  logic [3:0] m_done, rc, tc, sc;
  logic [32:0] q [5][$];
  logic [32:0] ev;
  logic [14:0] tabv [16];
  logic single = 1'b0, lvl = 1'b0;
  int err_total = 0, n_compared = 0, rs = 1;
  dbrd_top #(.DIVISOR_TABLE(TAB)) u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .reference_input, .rx_load_pulse, .rx_divisor_code,
    .tx_load_pulse, .tx_divisor_code, .load_pulse, .divisor_code, .rx_rate_out,
    .tx_rate_out, .rate_out, .quarter_ref_out);
  dbrd_rate_meter u_m [3:0] (.pclk(pclk), .period(m_per), .done(m_done),
    .rate({rate_out, quarter_ref_out, tx_rate_out, rx_rate_out}));
  initial forever #5 pclk = ~pclk;
  // free-running external reference at a sixth of pclk
  initial forever begin
    repeat (3) @(posedge pclk);
    reference_input <= ~reference_input;
  end
  task cmp(input [32:0] e, input [32:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task complete_run();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one transfer; the answer is judged by the watcher
  task apb(input [11:0] a, input w, input [31:0] d, input [32:0] e);
    int n;
    @(posedge pclk);
    q[4].push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      $display("mismatch at %0t: no pready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // load codes, let 3.5 us pass, then expect the periods
  task chk(input pin);
    int n;
    @(posedge pclk);
    rx_divisor_code <= rc;
    tx_divisor_code <= tc;
    divisor_code <= sc;
    rx_load_pulse <= pin;
    tx_load_pulse <= pin;
    load_pulse <= pin;
    @(posedge pclk);
    rx_load_pulse <= lvl;
    tx_load_pulse <= lvl;
    load_pulse <= lvl;
    // scrambled inputs must not leak through a closed latch
    if (!lvl) rx_divisor_code <= 4'($urandom);
    if (!lvl) tx_divisor_code <= 4'($urandom);
    if (!lvl) divisor_code <= 4'($urandom);
    repeat (350) @(posedge pclk);
    q[0].push_back(33'(tabv[single ? sc : rc] * rs));
    q[1].push_back(33'(tabv[tc] * rs));
    q[2].push_back(33'(4 * rs));
    q[3].push_back(33'(tabv[single ? sc : rc] * rs));
    n = 0;
    while (q[0].size() + q[1].size() + q[2].size() + q[3].size() > 0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) begin
      err_total++;
      $display("mismatch at %0t: rate not measured", $time);
    end
  endtask
  // watcher: oldest note against each result
  always @(posedge pclk) begin
    for (int k = 0; k < 4; k++)
      if (m_done[k] && q[k].size() > 0) cmp(q[k].pop_front(), {17'h0, m_per[k*16+:16]});
    if (pready && q[4].size() > 0) begin
      ev = q[4].pop_front();
      cmp(pwrite ? {ev[32], 32'h0} : ev, {pslverr, pwrite ? 32'h0 : prdata});
    end
  end
  initial begin
    for (int i = 0; i < 16; i++) tabv[i] = 15'(i + 3);
    void'($urandom(42));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(`DBRD_CTRL_ADDR, 1'b0, 32'h0, 33'h0);
    apb(12'h100, 1'b0, 32'h0, {1'b1, 32'h0});
    apb(12'h100, 1'b1, 32'h5, {1'b1, 32'h0});
    for (int i = 0; i < 16; i++)
      apb(`DBRD_TABLE_BASE + 12'(4 * i), 1'b0, 32'h0, {18'h0, tabv[i]});
    for (int c = 0; c < 16; c++) begin
      rc = 4'(c);
      tc = 4'($urandom);
      sc = 4'($urandom);
      chk(1'b1);
      apb(`DBRD_LOAD_ADDR, 1'b0, 32'h0, {25'h0, tc, rc});
    end
    lvl = 1'b1;
    repeat (3) begin
      rc = 4'($urandom);
      tc = 4'($urandom);
      chk(1'b1);
    end
    lvl = 1'b0;
    @(posedge pclk);
    rx_load_pulse <= 1'b0;
    tx_load_pulse <= 1'b0;
    rc = 4'h9;
    tc = 4'h2;
    apb(`DBRD_LOAD_ADDR, 1'b1, {22'h0, 2'b11, tc, rc}, 33'h0);
    chk(1'b0);
    single = 1'b1;
    apb(`DBRD_CTRL_ADDR, 1'b1, 32'h2, 33'h0);
    apb(`DBRD_CTRL_ADDR, 1'b0, 32'h0, 33'h2);
    chk(1'b1);
    single = 1'b0;
    rs = 6;
    apb(`DBRD_CTRL_ADDR, 1'b1, 32'h1, 33'h0);
    chk(1'b1);
    tabv[5] = 15'h0020;
    apb(`DBRD_TABLE_BASE + 12'h014, 1'b1, 32'h20, 33'h0);
    rc = 4'h5;
    chk(1'b1);
    complete_run();
  end
  // watchdog well beyond the planned run
  initial begin
    repeat (80000) @(posedge pclk);
    err_total++;
    $display("mismatch at %0t: watchdog", $time);
    complete_run();
  end
endmodule

// [hdl/dbrd_divisor_rom.v]
/*
  Re-programmable divisor table with one write port and three registered
  read ports. Assumes one clock and an active-low asynchronous reset that
  restores the parameter contents.
*/
`timescale 1ns/1ps
module dbrd_divisor_rom #(
  parameter WIDTH = 15,
  parameter DEPTH = 16,
  parameter AW = 4,
  parameter [WIDTH*DEPTH-1:0] INIT = {WIDTH*DEPTH{1'b0}}
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // read ports, data one cycle after address
  input wire [AW-1:0] ra_addr,
  output reg [WIDTH-1:0] ra_data,
  input wire [AW-1:0] rb_addr,
  output reg [WIDTH-1:0] rb_data,
  input wire [AW-1:0] rc_addr,
  output reg [WIDTH-1:0] rc_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // one flop row per entry, reset to its slice of the table
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_entry
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem[gi] <= INIT[gi*WIDTH +: WIDTH];
        end else if (wr_en && (wr_addr == gi)) begin
          mem[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // registered reads keep the divider paths short
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ra_data <= {WIDTH{1'b0}};
      rb_data <= {WIDTH{1'b0}};
      rc_data <= {WIDTH{1'b0}};
    end else begin
      ra_data <= mem[ra_addr];
      rb_data <= mem[rb_addr];
      rc_data <= mem[rc_addr];
    end
  end

endmodule

// [hdl/dbrd_top.v]
/*
  Dual baud-rate divider: receive and transmit dividers, select latches,
  quarter-rate reference output and an APB register slave. Control at
  0x000, software load at 0x004, status at 0x008, divisor table words
  from 0x040 to 0x07C; every access takes one wait state.
  Assumes all pins synchronous to pclk; the external reference is sampled
  and must run below half the pclk rate. Table writes also restart a
  divider whose current entry changes.
*/
`timescale 1ns/1ps
`include "dbrd_regs.vh"

module dbrd_top #(
  parameter CODE_W = `DBRD_CODE_W,
  parameter DIV_W = `DBRD_DIV_W,
  parameter [DIV_W*16-1:0] DIVISOR_TABLE = `DBRD_ROM_INIT
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // reference
  input wire reference_input,
  // receive select
  input wire rx_load_pulse,
  input wire [CODE_W-1:0] rx_divisor_code,
  // transmit select
  input wire tx_load_pulse,
  input wire [CODE_W-1:0] tx_divisor_code,
  // single-divider select
  input wire load_pulse,
  input wire [CODE_W-1:0] divisor_code,
  // rate outputs
  output reg rx_rate_out,
  output reg tx_rate_out,
  output reg rate_out,
  output reg quarter_ref_out
);

  // control register
  reg [1:0] ctrl;
  wire ext_ref;
  wire single_mode;
  assign ext_ref = ctrl[`DBRD_CTRL_EXT_REF];
  assign single_mode = ctrl[`DBRD_CTRL_SINGLE];

  // apb decode helpers
  wire apb_access;
  wire apb_commit;
  wire wr_commit;
  wire sel_ctrl;
  wire sel_load;
  wire sel_stat;
  wire sel_table;
  wire addr_ok;

  // decode: true when addr is a word of the divisor table
  function is_table;
    input [11:0] a;
    begin
      is_table = (a >= `DBRD_TABLE_BASE) && (a <= `DBRD_TABLE_END) && (a[1:0] == 2'h0);
    end
  endfunction

  assign sel_ctrl = (paddr == `DBRD_CTRL_ADDR);
  assign sel_load = (paddr == `DBRD_LOAD_ADDR);
  assign sel_stat = (paddr == `DBRD_STAT_ADDR);
  assign sel_table = is_table(paddr);
  assign addr_ok = sel_ctrl | sel_load | sel_stat | sel_table;

  // first access cycle prepares data; the second answers
  assign apb_access = psel & penable & ~pready;
  assign apb_commit = psel & penable & pready;
  assign wr_commit = apb_commit & pwrite & addr_ok;

  // per-register write strobes, each one cycle at the commit edge
  wire wr_ctrl;
  wire wr_load;
  wire wr_table;
  assign wr_ctrl = wr_commit & sel_ctrl;
  assign wr_load = wr_commit & sel_load;
  assign wr_table = wr_commit & sel_table;

  // reference tick: pclk itself or a rising edge of the pin
  reg ref_q;
  wire ref_tick;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= reference_input;
    end
  end
  assign ref_tick = ext_ref ? (reference_input & ~ref_q) : 1'b1;

  // quarter-rate count, independent of any selection
  reg [1:0] qcnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt <= 2'h0;
    end else if (ref_tick) begin
      qcnt <= qcnt + 2'h1;
    end
  end

  // output changes on every second tick, so it is square at a quarter rate
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quarter_ref_out <= 1'b0;
    end else if (ref_tick) begin
      quarter_ref_out <= qcnt[1] ^ qcnt[0];
    end
  end

  // software load strobes, one cycle at write commit
  wire sw_rx_go;
  wire sw_tx_go;
  assign sw_rx_go = wr_load & pwdata[`DBRD_LOAD_RX_GO];
  assign sw_tx_go = wr_load & pwdata[`DBRD_LOAD_TX_GO];

  // select latch sources; index 0 receive, 1 transmit
  wire [1:0] pin_load;
  wire [2*CODE_W-1:0] pin_code;
  wire [1:0] sw_load;
  wire [2*CODE_W-1:0] sw_code;
  assign pin_load[0] = single_mode ? load_pulse : rx_load_pulse;
  assign pin_load[1] = tx_load_pulse;
  assign pin_code[CODE_W-1:0] = single_mode ? divisor_code : rx_divisor_code;
  assign pin_code[2*CODE_W-1:CODE_W] = tx_divisor_code;
  assign sw_load = {sw_tx_go, sw_rx_go};
  assign sw_code = {pwdata[`DBRD_LOAD_TX_LSB +: CODE_W], pwdata[`DBRD_LOAD_RX_LSB +: CODE_W]};

  // latched codes and table lookups
  wire [2*CODE_W-1:0] code_q;
  wire [2*DIV_W-1:0] rom_div;
  wire [DIV_W-1:0] rom_apb;
  wire [1:0] div_out;

  dbrd_divisor_rom #(
    .WIDTH(DIV_W),
    .DEPTH(16),
    .AW(CODE_W),
    .INIT(DIVISOR_TABLE)
  ) u_rom (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_table),
    .wr_addr(paddr[5:2]),
    .wr_data(pwdata[DIV_W-1:0]),
    .ra_addr(code_q[CODE_W-1:0]),
    .ra_data(rom_div[DIV_W-1:0]),
    .rb_addr(code_q[2*CODE_W-1:CODE_W]),
    .rb_data(rom_div[2*DIV_W-1:DIV_W]),
    .rc_addr(paddr[5:2]),
    .rc_data(rom_apb)
  );

  // two identical, independent dividers
  genvar gd;
  generate
    for (gd = 0; gd < 2; gd = gd + 1) begin : g_div
      reg [CODE_W-1:0] code_r;
      reg [DIV_W-1:0] active;
      reg [DIV_W-1:0] cnt;
      reg dout;
      wire [CODE_W-1:0] next_code;
      wire [DIV_W-1:0] rom_n;
      wire [DIV_W-1:0] eff;
      wire [DIV_W-1:0] next_cnt;
      wire [DIV_W:0] half_sum;
      wire [DIV_W-1:0] half;
      wire restart;

      // each divider owns its slice of the shared buses
      assign code_q[gd*CODE_W +: CODE_W] = code_r;
      assign div_out[gd] = dout;

      assign rom_n = rom_div[gd*DIV_W +: DIV_W];
      // a modulus below two cannot toggle, so it runs as two
      assign eff = (active < 2) ? {{(DIV_W-2){1'b0}}, 2'h2} : active;
      assign next_cnt = (cnt >= eff - 1'b1) ? {DIV_W{1'b0}} : cnt + 1'b1;
      // odd moduli stay high one reference period longer; the spare bit
      // keeps the largest modulus from wrapping to a zero half
      assign half_sum = {1'b0, eff} + 1'b1;
      assign half = half_sum[DIV_W:1];
      // restart request whenever the looked-up divisor differs
      assign restart = (rom_n != active);

      // pin load wins over a software load; otherwise the code holds
      assign next_code = pin_load[gd] ? pin_code[gd*CODE_W +: CODE_W] :
        sw_load[gd] ? sw_code[gd*CODE_W +: CODE_W] : code_r;

      // level-sensitive latch: follows code while load is high
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          code_r <= {CODE_W{1'b0}};
        end else begin
          code_r <= next_code;
        end
      end

      // counter restarts as soon as the looked-up divisor changes
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          active <= {DIV_W{1'b0}};
          cnt <= {DIV_W{1'b0}};
          dout <= 1'b0;
        end else if (restart) begin
          active <= rom_n;
          cnt <= {DIV_W{1'b0}};
          dout <= 1'b1;
        end else if (ref_tick) begin
          cnt <= next_cnt;
          dout <= (next_cnt < half);
        end
      end
    end
  endgenerate

  // output flops mirror the divider states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_rate_out <= 1'b0;
      tx_rate_out <= 1'b0;
    end else begin
      rx_rate_out <= div_out[0];
      tx_rate_out <= div_out[1];
    end
  end

  // single-variant pin rides on the receive divider, whose latch takes
  // load_pulse and divisor_code while the single bit is set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_out <= 1'b0;
    end else begin
      rate_out <= div_out[0];
    end
  end

  // control register write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `DBRD_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= {pwdata[`DBRD_CTRL_SINGLE], pwdata[`DBRD_CTRL_EXT_REF]};
    end
  end

  // read mux, fed by the registered table port
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h00000000;
    if (sel_ctrl) begin
      next_prdata[1:0] = ctrl;
    end else if (sel_load) begin
      next_prdata[2*CODE_W-1:0] = code_q;
    end else if (sel_stat) begin
      next_prdata[`DBRD_STAT_RX_LSB +: CODE_W] = code_q[CODE_W-1:0];
      next_prdata[`DBRD_STAT_TX_LSB +: CODE_W] = code_q[2*CODE_W-1:CODE_W];
      next_prdata[`DBRD_STAT_RX_OUT] = div_out[0];
      next_prdata[`DBRD_STAT_TX_OUT] = div_out[1];
      next_prdata[`DBRD_STAT_QREF] = quarter_ref_out;
    end else if (sel_table) begin
      next_prdata[DIV_W-1:0] = rom_apb;
    end
  end

  // one wait state so the table read settles before the answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (apb_access) begin
      pready <= 1'b1;
      pslverr <= ~addr_ok;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // read data stands only with pready, so idle cycles show zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_access && !pwrite) begin
      prdata <= next_prdata;
    end else begin
      prdata <= 32'h00000000;
    end
  end

endmodule

// [inc/dbrd_regs.vh]
/*
  Register map, field positions, reset values and timing counts of the
  dual baud-rate divider. Assumes a 32-bit APB slave, 12-bit addresses.
*/
// Contract
// - Each divider picks one of 16 divisors from the code in its own select latch.
// - While rx_load_pulse is high the receive latch takes rx_divisor_code; in single mode the code uses load_pulse and divisor_code.
// - While tx_load_pulse is high the transmit latch takes tx_divisor_code.
// - A load pulse held high makes its latch follow the code inputs continuously.
// - Each divider is a 15-stage programmable divider, modulus up to 2^15-1.
// - Receive and transmit dividers run independently at their own rates.
// - quarter_ref_out always runs at one quarter of the reference rate.
// - In single-divider mode load_pulse loads divisor_code and rate_out follows it.
// - A newly latched code takes effect on the output within 3.5 microseconds.
`ifndef DBRD_REGS_VH
`define DBRD_REGS_VH

`define DBRD_CODE_W 4
`define DBRD_DIV_W 15
`define DBRD_ROM_DEPTH 16

// register byte addresses
`define DBRD_CTRL_ADDR 12'h000
`define DBRD_LOAD_ADDR 12'h004
`define DBRD_STAT_ADDR 12'h008
`define DBRD_TABLE_BASE 12'h040
`define DBRD_TABLE_END 12'h07C

// control fields
`define DBRD_CTRL_EXT_REF 0
`define DBRD_CTRL_SINGLE 1
`define DBRD_CTRL_RST 2'h0

// software load fields
`define DBRD_LOAD_RX_LSB 0
`define DBRD_LOAD_TX_LSB 4
`define DBRD_LOAD_RX_GO 8
`define DBRD_LOAD_TX_GO 9

// status fields
`define DBRD_STAT_RX_LSB 0
`define DBRD_STAT_TX_LSB 4
`define DBRD_STAT_RX_OUT 8
`define DBRD_STAT_TX_OUT 9
`define DBRD_STAT_QREF 10

// timing: clock period and longest delay to a new frequency
`define DBRD_CLK_NS 10
`define DBRD_NEW_FREQ_NS 3500
`define DBRD_NEW_FREQ_CYC (`DBRD_NEW_FREQ_NS / `DBRD_CLK_NS)

// default divisor table, entry 15 first
`define DBRD_ROM_INIT {15'h0100, 15'h00F0, 15'h00E0, 15'h00D0, 15'h00C0, 15'h00B0, \
  15'h00A0, 15'h0090, 15'h0080, 15'h0070, 15'h0060, 15'h0050, 15'h0040, 15'h0030, \
  15'h0020, 15'h0010}

`endif
